/* logic/usb_ep_buf.sv */
// buffering and handshake control for one non-control USB endpoint
//
// Functional notes
// - each direction holds up to two whole packets when double buffered
// - double buffering per direction enabled by its control bit
// - FIFO write appends to IN data, FIFO read pops next OUT byte
// - double buffered IN ready drops at once, without an IN event
// - IN present bit zero means both buffers free
// - ready with nothing loaded sends a zero-length packet
// - received packet sets OUT ready; count valid only while ready
// - clearing OUT ready with second packet waiting re-asserts it with event
// - OUT full status set while two packets are held
// - self-clear drops OUT ready after max-size bytes are read
// - self-set raises IN ready after max-size bytes are written
// - IN event on queued packet acknowledged (or sent, if iso), stall sent, or flush
// - IN event sets flag always; mask gates CPU flag; enable gates request
// - OUT receipt or stall sets OUT flag; same masking as IN
// - toggle-always flips data toggle after every queued packet sent, acknowledged or not
// - stalled bulk IN answers STALL, sets sent-stall, raises event
// - stalled bulk OUT discards data, answers STALL, sets sent-stall
// - iso IN with nothing loaded sends zero length, sets underrun
// - wait-for-SOF holds iso IN packet until next start of frame
// - iso OUT with no free buffer sets overrun and drops data
// - iso OUT bit errors set the data-error bit
// - reading a flag register clears its flag
// - wait-for-SOF answers zero length from ready until first SOF
//
// The placing of the registers and the address-and-strobe port were decided locally.
`include "usb_ep_params.svh"
module usb_ep_buf #(
    parameter int EP_NUM = `EPB_EP_NUM
) (
    input logic core_clk,
    input logic resetn,
    input logic [5:0] addr,
    input logic [7:0] wr_data,
    input logic wr_en,
    input logic rd_en,
    output logic [7:0] rd_data,
    input logic global_usb_irq_en,
    output logic usb_irq_req,
    output logic cpu_usb_flag_set,
    input logic lk_in_token,
    input logic lk_tx_take,
    input logic lk_tx_done,
    input logic lk_tx_ack,
    input logic lk_sof,
    input logic lk_rx_start,
    input logic lk_rx_valid,
    input logic [7:0] lk_rx_data,
    input logic lk_rx_end,
    input logic lk_rx_err,
    output usb_ep_pkg::reply_e lk_reply,
    output logic [`EPB_LW-1:0] lk_tx_len,
    output logic lk_tx_toggle,
    output logic [7:0] lk_tx_data
);
    usb_ep_pkg::state_s s;
    usb_ep_pkg::state_s n;
    logic in_ev;
    logic out_ev;
    logic in_byte;
    logic in_commit;
    logic in_flush;
    logic in_inc;
    logic in_dec;
    logic out_take;
    logic out_drop;
    logic out_inc;
    logic out_dec;
    logic out_we;
    usb_ep_pkg::len_t in_load_now;
    usb_ep_pkg::len_t out_rd_now;
    usb_ep_pkg::len_t out_len_now;

    usb_ep_mem_if #(.AW(`EPB_AW)) in_bus ();
    usb_ep_mem_if #(.AW(`EPB_AW)) out_bus ();

    function automatic usb_ep_pkg::len_t pick(input logic head, input usb_ep_pkg::len_t l0,
                                              input usb_ep_pkg::len_t l1);
        return head ? l1 : l0;
    endfunction

    function automatic logic has_room(input logic dbl, input logic [1:0] pkts);
        return pkts < (dbl ? 2'h2 : 2'h1);
    endfunction

    function automatic logic [7:0] flag_byte(input logic b);
        return {7'h00, b} << EP_NUM;
    endfunction

    always_comb
    begin
        n = s;
        n.reply = usb_ep_pkg::RPL_NONE;
        in_ev = 1'b0;
        out_ev = 1'b0;
        in_byte = 1'b0;
        in_commit = 1'b0;
        in_flush = 1'b0;
        in_inc = 1'b0;
        in_dec = 1'b0;
        out_take = 1'b0;
        out_drop = 1'b0;
        out_inc = 1'b0;
        out_dec = 1'b0;
        out_we = 1'b0;
        in_load_now = s.in_load;
        out_rd_now = s.out_readcnt;
        out_len_now = pick(s.out_head, s.out_len0, s.out_len1);
        // register writes; clears come first so a same-cycle set wins
        if (wr_en)
        begin
            case (addr)
                `EPB_OFS_POWER: n.wait_sof = wr_data[`EPB_POW_WAIT_SOF];
                `EPB_OFS_IN_MASK: n.in_mask = wr_data[EP_NUM];
                `EPB_OFS_OUT_MASK: n.out_mask = wr_data[EP_NUM];
                `EPB_OFS_IN_MAX: n.in_max = wr_data;
                `EPB_OFS_OUT_MAX: n.out_max = wr_data;
                `EPB_OFS_IN_CTRL_HIGH:
                begin
                    n.toggle_always = wr_data[`EPB_IH_TOGGLE_ALWAYS];
                    n.in_dbl = wr_data[`EPB_IH_DBL];
                    n.in_iso = wr_data[`EPB_IH_ISO];
                    n.in_in_ready_self_set_en = wr_data[`EPB_IH_IN_READY_SELF_SET_EN];
                end
                `EPB_OFS_OUT_CTRL_HIGH:
                begin
                    n.out_out_ready_self_clear_en = wr_data[`EPB_OH_OUT_READY_SELF_CLEAR_EN];
                    n.out_dbl = wr_data[`EPB_OH_DBL];
                    n.out_iso = wr_data[`EPB_OH_ISO];
                end
                `EPB_OFS_IN_CTRL_LOW:
                begin
                    n.in_send_stall = wr_data[`EPB_IL_SEND_STALL];
                    if (!wr_data[`EPB_IL_UNDERRUN])
                    begin
                        n.in_underrun = 1'b0;
                    end
                    if (!wr_data[`EPB_IL_SENT_STALL])
                    begin
                        n.in_sent_stall = 1'b0;
                    end
                    in_flush = wr_data[`EPB_IL_FLUSH];
                    in_commit = wr_data[`EPB_IL_READY] && !wr_data[`EPB_IL_FLUSH];
                end
                `EPB_OFS_OUT_CTRL_LOW:
                begin
                    n.out_send_stall = wr_data[`EPB_OL_SEND_STALL];
                    if (!wr_data[`EPB_OL_OVERRUN])
                    begin
                        n.out_overrun = 1'b0;
                    end
                    if (!wr_data[`EPB_OL_DATA_ERROR])
                    begin
                        n.out_data_error = 1'b0;
                    end
                    if (!wr_data[`EPB_OL_SENT_STALL])
                    begin
                        n.out_sent_stall = 1'b0;
                    end
                    out_drop = wr_data[`EPB_OL_FLUSH] || !wr_data[`EPB_OL_READY];
                end
                `EPB_OFS_FIFO: in_byte = 1'b1;
                default: ;
            endcase
        end
        // register reads, answered in the next cycle
        if (rd_en)
        begin
            case (addr)
                `EPB_OFS_POWER: n.rd_data = {s.wait_sof, 7'h00};
                `EPB_OFS_IN_FLAG:
                begin
                    n.rd_data = flag_byte(s.in_flag);
                    n.in_flag = 1'b0;
                end
                `EPB_OFS_OUT_FLAG:
                begin
                    n.rd_data = flag_byte(s.out_flag);
                    n.out_flag = 1'b0;
                end
                `EPB_OFS_IN_MASK: n.rd_data = flag_byte(s.in_mask);
                `EPB_OFS_OUT_MASK: n.rd_data = flag_byte(s.out_mask);
                `EPB_OFS_IN_MAX: n.rd_data = s.in_max;
                `EPB_OFS_OUT_MAX: n.rd_data = s.out_max;
                `EPB_OFS_IN_CTRL_LOW:
                    n.rd_data = {3'h0, s.in_sent_stall, s.in_send_stall, s.in_underrun,
                                 s.in_pkts != 2'h0,
                                 s.in_dbl ? s.in_pkts == 2'h2 : s.in_pkts != 2'h0};
                `EPB_OFS_IN_CTRL_HIGH:
                    n.rd_data = {4'h0, s.in_in_ready_self_set_en, s.in_iso, s.in_dbl, s.toggle_always};
                `EPB_OFS_OUT_CTRL_LOW:
                    n.rd_data = {2'h0, s.out_sent_stall, s.out_send_stall, s.out_data_error,
                                 s.out_overrun, s.out_pkts == 2'h2,
                                 s.out_pkts != 2'h0};
                `EPB_OFS_OUT_CTRL_HIGH:
                    n.rd_data = {5'h00, s.out_iso, s.out_dbl, s.out_out_ready_self_clear_en};
                `EPB_OFS_RX_COUNT_LOW:
                    n.rd_data = s.out_pkts != 2'h0 ? out_len_now[7:0] : 8'h00;
                `EPB_OFS_RX_COUNT_HIGH:
                    n.rd_data = s.out_pkts != 2'h0 ? {6'h00, out_len_now[9:8]} : 8'h00;
                `EPB_OFS_FIFO:
                begin
                    n.rd_data = out_bus.rdata;
                    out_take = 1'b1;
                end
                default: n.rd_data = 8'h00;
            endcase
        end
        // IN loading, commit by firmware or by reaching the max size
        if (in_byte)
        begin
            n.in_wr = s.in_wr + usb_ep_pkg::ptr_t'(1);
            in_load_now = s.in_load + usb_ep_pkg::len_t'(1);
            n.in_load = in_load_now;
            if (s.in_in_ready_self_set_en && in_load_now == {2'h0, s.in_max})
            begin
                in_commit = 1'b1;
            end
        end
        if (in_commit && has_room(s.in_dbl, s.in_pkts))
        begin
            if (s.in_tail)
            begin
                n.in_len1 = in_load_now;
            end
            else
            begin
                n.in_len0 = in_load_now;
            end
            n.in_tail = ~s.in_tail;
            n.in_load = '0;
            in_inc = 1'b1;
            if (s.in_pkts == 2'h0)
            begin
                n.sof_seen = 1'b0;
            end
        end
        if (lk_sof)
        begin
            n.sof_seen = 1'b1;
        end
        // IN token handling
        if (lk_in_token && !s.tx_busy)
        begin
            n.tx_len = '0;
            n.tx_toggle = s.toggle;
            if (s.in_send_stall && !s.in_iso)
            begin
                n.reply = usb_ep_pkg::RPL_STALL;
                n.in_sent_stall = 1'b1;
                in_ev = 1'b1;
            end
            else if (s.in_iso && (s.in_pkts == 2'h0 || (s.wait_sof && !s.sof_seen)))
            begin
                n.reply = usb_ep_pkg::RPL_DATA;
                if (s.in_pkts == 2'h0)
                begin
                    n.in_underrun = 1'b1;
                end
            end
            else if (s.in_pkts == 2'h0)
            begin
                n.reply = usb_ep_pkg::RPL_NAK;
            end
            else
            begin
                n.reply = usb_ep_pkg::RPL_DATA;
                n.tx_len = pick(s.in_head, s.in_len0, s.in_len1);
                n.tx_busy = 1'b1;
                n.in_rd = s.in_start;
            end
        end
        if (lk_tx_take && s.tx_busy)
        begin
            n.in_rd = s.in_rd + usb_ep_pkg::ptr_t'(1);
        end
        if (lk_tx_done && s.tx_busy)
        begin
            n.tx_busy = 1'b0;
            if (lk_tx_ack || s.toggle_always)
            begin
                n.toggle = ~s.toggle;
            end
            if (lk_tx_ack || s.in_iso)
            begin
                n.in_start = s.in_start + usb_ep_pkg::ptr_t'(pick(s.in_head, s.in_len0,
                                                                  s.in_len1));
                n.in_rd = n.in_start;
                n.in_head = ~s.in_head;
                in_dec = 1'b1;
                in_ev = 1'b1;
            end
            else
            begin
                n.in_rd = s.in_start;
            end
        end
        // flush drops the oldest packet, or the partial load when none is queued
        if (in_flush && !in_dec)
        begin
            in_ev = 1'b1;
            n.tx_busy = 1'b0;
            if (s.in_pkts != 2'h0)
            begin
                n.in_start = s.in_start + usb_ep_pkg::ptr_t'(pick(s.in_head, s.in_len0,
                                                                  s.in_len1));
                n.in_rd = n.in_start;
                n.in_head = ~s.in_head;
                in_dec = 1'b1;
            end
            else
            begin
                n.in_wr = s.in_start;
                n.in_load = '0;
            end
        end
        // OUT packet reception
        if (lk_rx_start)
        begin
            n.out_rxcnt = '0;
            if (s.out_send_stall && !s.out_iso)
            begin
                n.rx_mode = usb_ep_pkg::RX_STALL;
            end
            else if (!has_room(s.out_dbl, s.out_pkts))
            begin
                n.rx_mode = usb_ep_pkg::RX_FULL;
                if (s.out_iso)
                begin
                    n.out_overrun = 1'b1;
                end
            end
            else
            begin
                n.rx_mode = usb_ep_pkg::RX_STORE;
            end
        end
        else if (lk_rx_valid && s.rx_mode == usb_ep_pkg::RX_STORE)
        begin
            out_we = 1'b1;
            n.out_wr = s.out_wr + usb_ep_pkg::ptr_t'(1);
            n.out_rxcnt = s.out_rxcnt + usb_ep_pkg::len_t'(1);
        end
        else if (lk_rx_end)
        begin
            n.rx_mode = usb_ep_pkg::RX_IDLE;
            unique case (s.rx_mode)
                usb_ep_pkg::RX_STALL:
                begin
                    n.reply = usb_ep_pkg::RPL_STALL;
                    n.out_sent_stall = 1'b1;
                    out_ev = 1'b1;
                end
                usb_ep_pkg::RX_FULL: n.reply = s.out_iso ? usb_ep_pkg::RPL_NONE
                                                         : usb_ep_pkg::RPL_NAK;
                usb_ep_pkg::RX_STORE:
                begin
                    if (lk_rx_err && !s.out_iso)
                    begin
                        n.out_wr = s.out_wr - usb_ep_pkg::ptr_t'(s.out_rxcnt);
                    end
                    else
                    begin
                        if (s.out_tail)
                        begin
                            n.out_len1 = s.out_rxcnt;
                        end
                        else
                        begin
                            n.out_len0 = s.out_rxcnt;
                        end
                        n.out_tail = ~s.out_tail;
                        out_inc = 1'b1;
                        out_ev = 1'b1;
                        if (lk_rx_err)
                        begin
                            n.out_data_error = 1'b1;
                        end
                        n.reply = s.out_iso ? usb_ep_pkg::RPL_NONE : usb_ep_pkg::RPL_ACK;
                    end
                end
                usb_ep_pkg::RX_IDLE: ;
            endcase
        end
        // OUT unloading by firmware
        if (out_take && s.out_pkts != 2'h0)
        begin
            n.out_rd = s.out_rd + usb_ep_pkg::ptr_t'(1);
            out_rd_now = s.out_readcnt + usb_ep_pkg::len_t'(1);
            n.out_readcnt = out_rd_now;
            if (s.out_out_ready_self_clear_en && out_rd_now == {2'h0, s.out_max})
            begin
                out_drop = 1'b1;
            end
        end
        if (out_drop && s.out_pkts != 2'h0)
        begin
            n.out_start = s.out_start + usb_ep_pkg::ptr_t'(pick(s.out_head, s.out_len0,
                                                                s.out_len1));
            n.out_rd = n.out_start;
            n.out_head = ~s.out_head;
            n.out_readcnt = '0;
            out_dec = 1'b1;
            if (s.out_pkts == 2'h2)
            begin
                out_ev = 1'b1;
            end
        end
        n.in_pkts = s.in_pkts + {1'b0, in_inc} - {1'b0, in_dec};
        n.out_pkts = s.out_pkts + {1'b0, out_inc} - {1'b0, out_dec};
        // event flags are set whatever the mask; mask and enable gate the CPU side
        if (in_ev)
        begin
            n.in_flag = 1'b1;
        end
        if (out_ev)
        begin
            n.out_flag = 1'b1;
        end
        n.cpu_flag_set = (in_ev && s.in_mask) || (out_ev && s.out_mask);
        n.irq_req = n.cpu_flag_set && global_usb_irq_en;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= `EPB_STATE_RESET;
        end
        else
        begin
            s <= n;
        end
    end

    assign in_bus.we = in_byte;
    assign in_bus.waddr = s.in_wr;
    assign in_bus.wdata = wr_data;
    assign in_bus.raddr = n.in_rd;
    assign out_bus.we = out_we;
    assign out_bus.waddr = s.out_wr;
    assign out_bus.wdata = lk_rx_data;
    assign out_bus.raddr = n.out_rd;

    usb_ep_mem #(.AW(`EPB_AW)) in_mem (
        .core_clk(core_clk),
        .resetn(resetn),
        .port(in_bus.store)
    );

    usb_ep_mem #(.AW(`EPB_AW)) out_mem (
        .core_clk(core_clk),
        .resetn(resetn),
        .port(out_bus.store)
    );

    assign rd_data = s.rd_data;
    assign usb_irq_req = s.irq_req;
    assign cpu_usb_flag_set = s.cpu_flag_set;
    assign lk_reply = s.reply;
    assign lk_tx_len = s.tx_len;
    assign lk_tx_toggle = s.tx_toggle;
    assign lk_tx_data = in_bus.rdata;
endmodule

/* logic/usb_ep_params.svh */
// register offsets, field positions and reset values of the endpoint buffer block
`ifndef USB_EP_PARAMS_SVH
`define USB_EP_PARAMS_SVH

`define EPB_AW 6
`define EPB_LW 10
`define EPB_DEPTH 64

`define EPB_OFS_POWER 6'h01
`define EPB_OFS_IN_FLAG 6'h02
`define EPB_OFS_OUT_FLAG 6'h04
`define EPB_OFS_IN_MASK 6'h07
`define EPB_OFS_OUT_MASK 6'h09
`define EPB_OFS_IN_MAX 6'h10
`define EPB_OFS_IN_CTRL_LOW 6'h11
`define EPB_OFS_IN_CTRL_HIGH 6'h12
`define EPB_OFS_OUT_MAX 6'h13
`define EPB_OFS_OUT_CTRL_LOW 6'h14
`define EPB_OFS_OUT_CTRL_HIGH 6'h15
`define EPB_OFS_RX_COUNT_LOW 6'h16
`define EPB_OFS_RX_COUNT_HIGH 6'h17
`define EPB_OFS_FIFO 6'h20

`define EPB_POW_WAIT_SOF 7

`define EPB_IL_READY 0
`define EPB_IL_PRESENT 1
`define EPB_IL_UNDERRUN 2
`define EPB_IL_SEND_STALL 3
`define EPB_IL_SENT_STALL 4
`define EPB_IL_FLUSH 5

`define EPB_IH_TOGGLE_ALWAYS 0
`define EPB_IH_DBL 1
`define EPB_IH_ISO 2
`define EPB_IH_IN_READY_SELF_SET_EN 3

`define EPB_OL_READY 0
`define EPB_OL_FULL 1
`define EPB_OL_OVERRUN 2
`define EPB_OL_DATA_ERROR 3
`define EPB_OL_SEND_STALL 4
`define EPB_OL_SENT_STALL 5
`define EPB_OL_FLUSH 6

`define EPB_OH_OUT_READY_SELF_CLEAR_EN 0
`define EPB_OH_DBL 1
`define EPB_OH_ISO 2

`define EPB_EP_NUM 1
`define EPB_STATE_RESET '0

`endif

/* logic/usb_ep_pkg.sv */
// types of the endpoint buffer block
`include "usb_ep_params.svh"
package usb_ep_pkg;
    typedef logic [`EPB_AW-1:0] ptr_t;
    typedef logic [`EPB_LW-1:0] len_t;
    typedef enum logic [2:0] {RPL_NONE, RPL_NAK, RPL_ACK, RPL_STALL, RPL_DATA} reply_e;
    typedef enum logic [1:0] {RX_IDLE, RX_STORE, RX_STALL, RX_FULL} rx_state_e;

    typedef struct packed {
        ptr_t in_wr;
        ptr_t in_rd;
        ptr_t in_start;
        len_t in_load;
        len_t in_len0;
        len_t in_len1;
        logic in_tail;
        logic in_head;
        logic [1:0] in_pkts;
        logic in_underrun;
        logic in_send_stall;
        logic in_sent_stall;
        logic toggle_always;
        logic in_dbl;
        logic in_iso;
        logic in_in_ready_self_set_en;
        logic [7:0] in_max;
        logic toggle;
        logic sof_seen;
        logic tx_busy;
        ptr_t out_wr;
        ptr_t out_rd;
        ptr_t out_start;
        len_t out_rxcnt;
        len_t out_len0;
        len_t out_len1;
        logic out_tail;
        logic out_head;
        logic [1:0] out_pkts;
        len_t out_readcnt;
        logic out_overrun;
        logic out_data_error;
        logic out_send_stall;
        logic out_sent_stall;
        logic out_out_ready_self_clear_en;
        logic out_dbl;
        logic out_iso;
        logic [7:0] out_max;
        rx_state_e rx_mode;
        logic in_flag;
        logic out_flag;
        logic in_mask;
        logic out_mask;
        logic wait_sof;
        logic [7:0] rd_data;
        reply_e reply;
        len_t tx_len;
        logic tx_toggle;
        logic irq_req;
        logic cpu_flag_set;
    } state_s;
endpackage

/* logic/usb_ep_mem_if.sv */
// byte memory port bundle between buffer control and its memories
interface usb_ep_mem_if #(parameter int AW = 6) ();
    logic we;
    logic [AW-1:0] waddr;
    logic [7:0] wdata;
    logic [AW-1:0] raddr;
    logic [7:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* logic/usb_ep_mem.sv */
// byte memory, one write port and one registered read port
module usb_ep_mem #(
    parameter int AW = 6
) (
    input logic core_clk,
    input logic resetn,
    usb_ep_mem_if.store port
);
    logic [7:0] mem [0:(1 << AW)-1];

    always_ff @(posedge core_clk)
    begin
        if (port.we)
        begin
            mem[port.waddr] <= port.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            port.rdata <= 8'h00;
        end
        else
        begin
            port.rdata <= mem[port.raddr];
        end
    end
endmodule

/* verif/usb_ep_buf_props.sv */
// assertion checker on the endpoint buffer block ports
`include "usb_ep_params.svh"
module usb_ep_buf_props (
    input logic core_clk,
    input logic resetn,
    input logic global_usb_irq_en,
    input logic usb_irq_req,
    input logic cpu_usb_flag_set,
    input logic lk_in_token,
    input logic lk_rx_end,
    input usb_ep_pkg::reply_e lk_reply,
    input logic [`EPB_LW-1:0] lk_tx_len,
    input logic lk_tx_toggle
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_rx_ok;
        lk_rx_end ##1 lk_reply == usb_ep_pkg::RPL_ACK;
    endsequence
    a_irq_with_flag: assert property (usb_irq_req |-> cpu_usb_flag_set)
        else $error("request without cpu flag");
    a_irq_needs_en: assert property (usb_irq_req |-> $past(global_usb_irq_en))
        else $error("request while disabled");
    a_reply_once: assert property (lk_reply != 0 |=> lk_reply == 0)
        else $error("reply longer than one cycle");
    a_data_cause: assert property (lk_reply == usb_ep_pkg::RPL_DATA
        |-> $past(lk_in_token))
        else $error("data reply without token");
    a_ack_cause: assert property (lk_reply == usb_ep_pkg::RPL_ACK |-> $past(lk_rx_end))
        else $error("ack without packet end");
    a_stall_cause: assert property (lk_reply == usb_ep_pkg::RPL_STALL
        |-> $past(lk_in_token) || $past(lk_rx_end))
        else $error("stall without token");
    a_rx_no_data: assert property (lk_rx_end |=> lk_reply != usb_ep_pkg::RPL_DATA)
        else $error("data reply to out packet");
    a_len_hold: assert property (!lk_in_token
        |=> $stable(lk_tx_len) && $stable(lk_tx_toggle))
        else $error("length or toggle moved");
    c_rx_ok: cover property (s_rx_ok);
endmodule

/* verif/usb_host_model.sv */
// host packet engine model on the endpoint link
module usb_host_model (
    input wire logic core_clk,
    input usb_ep_pkg::reply_e lk_reply,
    input wire logic [9:0] lk_tx_len,
    input wire logic [7:0] lk_tx_data,
    output logic lk_in_token,
    output logic lk_tx_take,
    output logic lk_tx_done,
    output logic lk_tx_ack,
    output logic lk_rx_start,
    output logic lk_rx_valid,
    output logic [7:0] lk_rx_data,
    output logic lk_rx_end,
    output logic lk_rx_err
);
    timeunit 1ns;
    timeprecision 1ps;
    usb_ep_pkg::reply_e rep;
    logic [9:0] len;
    logic [7:0] b0;
    initial {lk_in_token, lk_tx_take, lk_tx_done, lk_tx_ack, lk_rx_start, lk_rx_valid,
        lk_rx_data, lk_rx_end, lk_rx_err} = '0;
    task automatic in_pkt();
        @(posedge core_clk) lk_in_token <= 1'b1;
        @(posedge core_clk) lk_in_token <= 1'b0;
        @(posedge core_clk) rep = lk_reply;
        {len, b0} = {lk_tx_len, lk_tx_data};
        if (rep == usb_ep_pkg::RPL_DATA)
        begin
            if (len != 0)
                lk_tx_take <= 1'b1;
            repeat (len) @(posedge core_clk);
            {lk_tx_take, lk_tx_done, lk_tx_ack} <= 3'b011;
            @(posedge core_clk) {lk_tx_done, lk_tx_ack} <= 2'b00;
        end
    endtask
    task automatic out_pkt(input int n, input logic err);
        @(posedge core_clk) lk_rx_start <= 1'b1;
        for (int i = 0; i < n; i++)
            @(posedge core_clk) {lk_rx_start, lk_rx_valid, lk_rx_data} <= {2'b01, 8'hA0 + 8'(i)};
        // released data line shows no stale byte
        @(posedge core_clk) {lk_rx_start, lk_rx_valid, lk_rx_end, lk_rx_err} <= {3'b001, err};
        lk_rx_data <= ~lk_rx_data;
        @(posedge core_clk) {lk_rx_end, lk_rx_err} <= 2'b00;
        @(posedge core_clk) rep = lk_reply;
    endtask
endmodule

/* verif/tb.sv */
// top testbench of the endpoint buffer block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, resetn = 0, wr_en = 0, rd_en = 0, global_usb_irq_en = 1, lk_sof = 0;
    logic [5:0] addr = '0;
    logic [7:0] wr_data = '0, rd_data, d, lk_tx_data, lk_rx_data;
    logic usb_irq_req, cpu_usb_flag_set, lk_tx_toggle, lk_in_token, lk_tx_take, lk_tx_done;
    logic lk_tx_ack, lk_rx_start, lk_rx_valid, lk_rx_end, lk_rx_err;
    usb_ep_pkg::reply_e lk_reply;
    logic [9:0] lk_tx_len;
    int err_total, n_tests, n_irq;
    usb_ep_buf usb_ep_buf_i (.core_clk, .resetn, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
        .global_usb_irq_en, .usb_irq_req, .cpu_usb_flag_set, .lk_in_token, .lk_tx_take,
        .lk_tx_done, .lk_tx_ack, .lk_sof, .lk_rx_start, .lk_rx_valid, .lk_rx_data, .lk_rx_end,
        .lk_rx_err, .lk_reply, .lk_tx_len, .lk_tx_toggle, .lk_tx_data);
    usb_host_model usb_host_model_i (.core_clk, .lk_reply, .lk_tx_len, .lk_tx_data, .lk_in_token,
        .lk_tx_take, .lk_tx_done, .lk_tx_ack, .lk_rx_start, .lk_rx_valid, .lk_rx_data,
        .lk_rx_end, .lk_rx_err);
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) n_irq += usb_irq_req;
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge core_clk) {wr_en, addr, wr_data} <= {1'b1, a, v};
        @(posedge core_clk) wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge core_clk) {rd_en, addr} <= {1'b1, a};
        @(posedge core_clk) rd_en <= 1'b0;
        @(posedge core_clk) d = rd_data;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_in();
        rd(6'h12);
        chk(d, 8'h00);
        wr(6'h07, 8'h02);
        for (int i = 0; i < 3; i++)
            wr(6'h20, 8'hB0 + 8'(i));
        wr(6'h11, 8'h01);
        usb_host_model_i.in_pkt();
        chk(8'(usb_host_model_i.rep), 8'h04);
        chk(usb_host_model_i.len[7:0], 8'h03);
        chk(usb_host_model_i.b0, 8'hB0);
        rd(6'h02);
        chk(d, 8'h02);
        rd(6'h02);
        chk(d, 8'h00);
        chk(8'(n_irq), 8'h01);
        wr(6'h11, 8'h01);
        usb_host_model_i.in_pkt();
        chk(usb_host_model_i.len[7:0], 8'h00);
    endtask
    task automatic t_dbl();
        wr(6'h12, 8'h02);
        wr(6'h20, 8'h5A);
        wr(6'h11, 8'h01);
        rd(6'h11);
        chk(d & 8'h03, 8'h02);
        chk(8'(n_irq), 8'h02);
        global_usb_irq_en <= 1'b0;
        usb_host_model_i.in_pkt();
        chk(usb_host_model_i.len[7:0], 8'h01);
    endtask
    task automatic t_out();
        usb_host_model_i.out_pkt(2, 1'b0);
        chk(8'(usb_host_model_i.rep), 8'h02);
        chk(8'(n_irq), 8'h02);
        rd(6'h16);
        chk(d, 8'h02);
        rd(6'h20);
        chk(d, 8'hA0);
        rd(6'h20);
        chk(d, 8'hA1);
        wr(6'h14, 8'h00);
        rd(6'h14);
        chk(d & 8'h01, 8'h00);
    endtask
    task automatic t_stall_iso();
        wr(6'h11, 8'h08);
        usb_host_model_i.in_pkt();
        chk(8'(usb_host_model_i.rep), 8'h03);
        rd(6'h11);
        chk(d & 8'h18, 8'h18);
        wr(6'h11, 8'h00);
        wr(6'h12, 8'h04);
        usb_host_model_i.in_pkt();
        chk(usb_host_model_i.len[7:0], 8'h00);
        rd(6'h11);
        chk(d & 8'h04, 8'h04);
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        t_in();
        t_dbl();
        t_out();
        t_stall_iso();
        complete_run();
    end
    initial
    begin
        #20000;
        err_total++;
        complete_run();
    end
endmodule
bind usb_ep_buf usb_ep_buf_props usb_ep_buf_props_i (.core_clk(core_clk), .resetn(resetn),
    .global_usb_irq_en(global_usb_irq_en), .usb_irq_req(usb_irq_req),
    .cpu_usb_flag_set(cpu_usb_flag_set), .lk_in_token(lk_in_token), .lk_rx_end(lk_rx_end),
    .lk_reply(lk_reply), .lk_tx_len(lk_tx_len), .lk_tx_toggle(lk_tx_toggle));
